// ==== hw/scwl_defines.svh ====
// Constants for the serial control word loader: field positions and widths.
// Assumes inclusion by bare name from the package and the modules.
// Summary of operation
// - Sample data on each serial clock rise while chip select is low
// - Chip select rise latches word, applies it
// - Bit 0 picks microphone input
// - Bits 1-2 pick pre-process input
// - Bits 3-6 set input gain
// - Bit 7 enables compressor
// - Bits 8, 9 enable input filters
// - Three four-bit trim gain fields
// - Bit 14 picks post-process source
// - Bit 15 enables pre-emphasis
// - Bits 16-17 set post-limiter filter
// - Bits 18-19 select output drive path
// - Bits 20-22 reference drive attenuation
// - Bit 27 enables output drives
// - Bits 28-31 main drive attenuation
// - Bit 36 enables receive audio output
// - Bits 37-39 squelch filter gain
// - Bit 40 squelch filter bandwidth
// - Bits 41-44 squelch threshold code
// - Bits 45-46 select squelch source
`ifndef SCWL_DEFINES_SVH
`define SCWL_DEFINES_SVH
// ----------------------------------------
// Word geometry
// ----------------------------------------
`define SCWL_WORD_W 47
`define SCWL_CNT_W 6
`define SCWL_WORD_RST 47'h0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCWL_MIC_SEL 0
`define SCWL_IN_SEL_LO 1
`define SCWL_IN_GAIN_LO 3
`define SCWL_COMP_EN 7
`define SCWL_HPF_EN 8
`define SCWL_LPF_EN 9
`define SCWL_PRE_TRIM_LO 10
`define SCWL_PROC_SEL 14
`define SCWL_PREEMPH_EN 15
`define SCWL_PLF_WIDE 16
`define SCWL_PLF_EN 17
`define SCWL_DRV_SEL_LO 18
`define SCWL_REF_ATT_LO 20
`define SCWL_REF_TRIM_LO 23
`define SCWL_OUT_EN 27
`define SCWL_MAIN_ATT_LO 28
`define SCWL_MAIN_TRIM_LO 32
`define SCWL_RX_OUT_EN 36
`define SCWL_SQ_GAIN_LO 37
`define SCWL_SQ_WIDE 40
`define SCWL_SQ_THR_LO 41
`define SCWL_SQ_SRC_LO 45
`endif

// ==== hw/scwl_pkg.sv ====
// Types for the serial control word loader.
// Assumes the defines header is on the include path.
`include "scwl_defines.svh"
package scwl_pkg;
	typedef logic [`SCWL_WORD_W-1:0] scwl_word_t;
	typedef logic [`SCWL_CNT_W-1:0] scwl_cnt_t;
	typedef enum logic [1:0] {
		SCWL_SQ_BIAS = 2'h0,
		SCWL_SQ_NOISE = 2'h1,
		SCWL_SQ_RSSI = 2'h2,
		SCWL_SQ_RSVD = 2'h3
	} scwl_sq_src_t;
	typedef enum logic [1:0] {
		SCWL_IDLE = 2'h0,
		SCWL_SHIFT = 2'h1
	} scwl_state_t;
endpackage

// ==== hw/scwl_shifter.sv ====
// Serial-clock-domain shift stage for the control word loader.
// Assumes the serial clock only pulses while chip select is low.
`include "scwl_defines.svh"
module scwl_shifter
	import scwl_pkg::*;
(
	// Link side
	input wire logic i_sclk,
	input wire logic i_sdata,
	input wire logic i_cs_n,
	// Core side
	scwl_xfer_if.src xfer
);
	scwl_word_t shift_reg;
	scwl_word_t shift_next;
	scwl_cnt_t cnt_reg;
	scwl_cnt_t cnt_next;
	logic frame_open_reg;

	// ----------------------------------------
	// Shift on serial clock, staged apart from active word
	// ----------------------------------------
	always_comb begin
		shift_next = {shift_reg[`SCWL_WORD_W-2:0], i_sdata};
		// Count restarts on the first shift edge of each frame
		if (!frame_open_reg) begin
			cnt_next = 6'h01;
		end else begin
			cnt_next = (cnt_reg == 6'h3f) ? cnt_reg : cnt_reg + 6'h01;
		end
	end

	always_ff @(posedge i_sclk) begin
		if (!i_cs_n) begin
			shift_reg <= shift_next;
			cnt_reg <= cnt_next;
		end
	end

	// ----------------------------------------
	// Chip select rise closes the frame
	// ----------------------------------------
	// Set by the first shift edge, cleared at once by the chip select rise.
	// Its fall marks a closed frame; no unreset toggle can leak into the core.
	always_ff @(posedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			frame_open_reg <= 1'b0;
		end else begin
			frame_open_reg <= 1'b1;
		end
	end

	assign xfer.word = shift_reg;
	assign xfer.toggle = frame_open_reg;
	assign xfer.count = cnt_reg;
endmodule

// ==== hw/scwl_top.sv ====
// Top of the serial control word loader: crossing, active word, field outputs.
// Assumes I_CLK is free running; the three serial lines come from the host.
`include "scwl_defines.svh"
module scwl_top
	import scwl_pkg::*;
(
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Serial link
	input wire logic I_SCLK,
	input wire logic I_SDATA,
	input wire logic I_CS_N,
	// Pre-process path
	output logic O_MIC_SEL,
	output logic [1:0] O_IN_SEL,
	output logic [3:0] O_IN_GAIN,
	output logic O_COMP_EN,
	output logic O_HPF_EN,
	output logic O_LPF_EN,
	output logic [3:0] O_PRE_TRIM,
	// Post-process path
	output logic O_PROC_SEL,
	output logic O_PREEMPH_EN,
	output logic O_PLF_WIDE,
	output logic O_PLF_EN,
	output logic [1:0] O_DRV_SEL,
	output logic [2:0] O_REF_ATT,
	output logic [3:0] O_REF_TRIM,
	output logic O_OUT_EN,
	output logic [3:0] O_MAIN_ATT,
	output logic [3:0] O_MAIN_TRIM,
	output logic O_RX_OUT_EN,
	// Squelch system
	output logic [2:0] O_SQ_GAIN,
	output logic O_SQ_WIDE,
	output logic [3:0] O_SQ_THR,
	output logic [1:0] O_SQ_SRC,
	// Status
	output logic O_LOAD_PULSE,
	output logic O_LOADED
);
	scwl_xfer_if xfer ();

	scwl_shifter u_shifter (
		.i_sclk(I_SCLK),
		.i_sdata(I_SDATA),
		.i_cs_n(I_CS_N),
		.xfer(xfer)
	);

	// ----------------------------------------
	// Toggle crossing into the core clock
	// ----------------------------------------
	logic tog_s1_reg;
	logic tog_s2_reg;
	logic tog_s3_reg;
	logic tog_s1_next;
	logic tog_s2_next;
	logic tog_s3_next;
	logic load_evt;

	always_comb begin
		tog_s1_next = xfer.toggle;
		tog_s2_next = tog_s1_reg;
		tog_s3_next = tog_s2_reg;
		// Frame-open falling edge: chip select has risen after a shifted frame
		load_evt = tog_s3_reg & ~tog_s2_reg;
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			tog_s1_reg <= 1'b0;
			tog_s2_reg <= 1'b0;
			tog_s3_reg <= 1'b0;
		end else begin
			tog_s1_reg <= tog_s1_next;
			tog_s2_reg <= tog_s2_next;
			tog_s3_reg <= tog_s3_next;
		end
	end

	// ----------------------------------------
	// Active configuration word
	// ----------------------------------------
	// The staged word is stable here: the host holds chip select high
	// far longer than the crossing, and shifting needs chip select low.
	scwl_word_t act_reg;
	scwl_word_t act_next;
	logic pulse_reg;
	logic pulse_next;
	logic loaded_reg;
	logic loaded_next;

	always_comb begin
		act_next = act_reg;
		pulse_next = 1'b0;
		loaded_next = loaded_reg;
		if (load_evt) begin
			act_next = xfer.word;
			pulse_next = 1'b1;
			loaded_next = 1'b1;
		end
	end

	// Reset value is a defined zero; software must still load a word first
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			act_reg <= `SCWL_WORD_RST;
			pulse_reg <= 1'b0;
			loaded_reg <= 1'b0;
		end else begin
			act_reg <= act_next;
			pulse_reg <= pulse_next;
			loaded_reg <= loaded_next;
		end
	end

	// ----------------------------------------
	// Field decode, all straight from the active word
	// ----------------------------------------
	assign O_MIC_SEL = act_reg[`SCWL_MIC_SEL];
	assign O_IN_SEL = act_reg[`SCWL_IN_SEL_LO +: 2];
	assign O_IN_GAIN = act_reg[`SCWL_IN_GAIN_LO +: 4];
	assign O_COMP_EN = act_reg[`SCWL_COMP_EN];
	assign O_HPF_EN = act_reg[`SCWL_HPF_EN];
	assign O_LPF_EN = act_reg[`SCWL_LPF_EN];
	assign O_PRE_TRIM = act_reg[`SCWL_PRE_TRIM_LO +: 4];
	assign O_PROC_SEL = act_reg[`SCWL_PROC_SEL];
	assign O_PREEMPH_EN = act_reg[`SCWL_PREEMPH_EN];
	assign O_PLF_WIDE = act_reg[`SCWL_PLF_WIDE];
	assign O_PLF_EN = act_reg[`SCWL_PLF_EN];
	assign O_DRV_SEL = act_reg[`SCWL_DRV_SEL_LO +: 2];
	assign O_REF_ATT = act_reg[`SCWL_REF_ATT_LO +: 3];
	assign O_REF_TRIM = act_reg[`SCWL_REF_TRIM_LO +: 4];
	assign O_OUT_EN = act_reg[`SCWL_OUT_EN];
	assign O_MAIN_ATT = act_reg[`SCWL_MAIN_ATT_LO +: 4];
	assign O_MAIN_TRIM = act_reg[`SCWL_MAIN_TRIM_LO +: 4];
	assign O_RX_OUT_EN = act_reg[`SCWL_RX_OUT_EN];
	assign O_SQ_GAIN = act_reg[`SCWL_SQ_GAIN_LO +: 3];
	assign O_SQ_WIDE = act_reg[`SCWL_SQ_WIDE];
	assign O_SQ_THR = act_reg[`SCWL_SQ_THR_LO +: 4];
	// Reserved code is passed through unchanged; the host must avoid it
	assign O_SQ_SRC = act_reg[`SCWL_SQ_SRC_LO +: 2];
	assign O_LOAD_PULSE = pulse_reg;
	assign O_LOADED = loaded_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence seq_toggle_seen;
		tog_s3_reg && !tog_s2_reg;
	endsequence

	AST_LOAD_COPIES: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		seq_toggle_seen |=> (act_reg == $past(xfer.word)) && pulse_reg)
		else $error("active word not loaded on chip select event");
	AST_HOLD_NO_EVT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!load_evt |=> $stable(act_reg))
		else $error("active word changed without a load");
	AST_PULSE_ONE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |=> !pulse_reg)
		else $error("load pulse longer than one cycle");
	AST_LOADED_STICKY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> loaded_reg ##1 loaded_reg)
		else $error("loaded flag dropped");
	AST_SQ_FIELD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_SQ_SRC == $past(xfer.word[46:45]))
		else $error("squelch source field misplaced");
	AST_MIC_FIELD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_MIC_SEL == $past(xfer.word[0]))
		else $error("microphone select misplaced");
	AST_MAIN_ATT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_MAIN_ATT == $past(xfer.word[31:28]))
		else $error("main attenuation misplaced");
	AST_OUT_EN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_OUT_EN == $past(xfer.word[27]))
		else $error("output enable misplaced");
	AST_IN_SEL: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_IN_SEL == $past(xfer.word[2:1]))
		else $error("input select misplaced");
	AST_IN_GAIN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_IN_GAIN == $past(xfer.word[6:3]))
		else $error("input gain misplaced");
	AST_COMP_EN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_COMP_EN == $past(xfer.word[7]))
		else $error("compressor enable misplaced");
	AST_FILT_EN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> {O_LPF_EN, O_HPF_EN} == $past(xfer.word[9:8]))
		else $error("input filter enables misplaced");
	AST_PRE_TRIM: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_PRE_TRIM == $past(xfer.word[13:10]))
		else $error("pre-process trim misplaced");
	AST_PROC_SEL: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_PROC_SEL == $past(xfer.word[14]))
		else $error("process select misplaced");
	AST_PREEMPH: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_PREEMPH_EN == $past(xfer.word[15]))
		else $error("pre-emphasis enable misplaced");
	AST_PLF: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> {O_PLF_EN, O_PLF_WIDE} == $past(xfer.word[17:16]))
		else $error("post-limiter filter misplaced");
	AST_DRV_SEL: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_DRV_SEL == $past(xfer.word[19:18]))
		else $error("drive select misplaced");
	AST_REF_ATT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_REF_ATT == $past(xfer.word[22:20]))
		else $error("reference attenuation misplaced");
	AST_REF_TRIM: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_REF_TRIM == $past(xfer.word[26:23]))
		else $error("reference trim misplaced");
	AST_MAIN_TRIM: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_MAIN_TRIM == $past(xfer.word[35:32]))
		else $error("main trim misplaced");
	AST_RX_OUT: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_RX_OUT_EN == $past(xfer.word[36]))
		else $error("receive output enable misplaced");
	AST_SQ_GAIN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_SQ_GAIN == $past(xfer.word[39:37]))
		else $error("squelch gain misplaced");
	AST_SQ_WIDE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_SQ_WIDE == $past(xfer.word[40]))
		else $error("squelch bandwidth misplaced");
	AST_SQ_THR: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		pulse_reg |-> O_SQ_THR == $past(xfer.word[44:41]))
		else $error("squelch threshold misplaced");
	AST_SHIFT_IN: assert property (@(posedge I_SCLK)
		!I_CS_N |=> xfer.word[0] == $past(I_SDATA))
		else $error("serial bit not sampled");
endmodule

// ==== hw/scwl_xfer_if.sv ====
// Carries a finished staged word from the serial clock domain to the core.
// Assumes a toggle handshake: the word holds still while toggle differs.
interface scwl_xfer_if;
	import scwl_pkg::*;
	scwl_word_t word;
	logic toggle;
	logic [5:0] count;
	modport src (output word, output toggle, output count);
	modport dst (input word, input toggle, input count);
endinterface

// ==== tb/scwl_host_model.sv ====
// Host model for the serial control word loader: drives the three serial lines.
// Assumes the bench calls its tasks; the serial clock rests low between frames.
module scwl_host_model
	import scwl_pkg::*;
(
	// Serial link
	output logic o_sclk,
	output logic o_sdata,
	output logic o_cs_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// -------------------------------------------
	// Timing
	// -------------------------------------------
	// Pulse widths at the minimum; this also covers data setup and hold
	localparam int HALF_NS = 600;
	initial begin
		o_sclk = 1'b0;
		o_sdata = 1'b0;
		o_cs_n = 1'b1;
	end
	// -------------------------------------------
	// Frame tasks
	// -------------------------------------------
	// Whole word, top bit first; chip select is left low for the bench
	task automatic shift_word(input scwl_word_t w);
		#HALF_NS;
		o_cs_n <= 1'b0;
		#HALF_NS;
		for (int i = $bits(scwl_word_t) - 1; i >= 0; i--) begin
			o_sdata <= w[i];
			#HALF_NS;
			o_sclk <= 1'b1;
			#HALF_NS;
			o_sclk <= 1'b0;
		end
		#HALF_NS;
	endtask
	// Deselect; data line flips so a stale level is never mistaken for a hold
	task automatic latch_word();
		o_cs_n <= 1'b1;
		o_sdata <= ~o_sdata;
	endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the serial control word loader top.
// Assumes the host model paces the link; core clock 25 MHz.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import scwl_pkg::*;
	logic clk, rst_n, sclk, sdata, cs_n;
	logic mic, comp, hpf, lpf, proc, pre, plfw, plfe, oen, rxen, sqw, pulse, loaded;
	logic [1:0] in_sel, drv, src;
	logic [2:0] ratt, sqg;
	logic [3:0] gain, ptrim, rtrim, matt, mtrim, thr;
	scwl_word_t act, prev;
	int error_cnt = 0;
	int compares = 0;
	int pulses = 0;
	scwl_word_t pats[6] = '{47'h0, 47'h2aaa_aaaa_aaaa, 47'h5555_5555_5555,
		47'h1fff_ffff_fffe, 47'h4123_4567_89ab, 47'h3edc_ba98_7654};
	assign act = {src, thr, sqw, sqg, rxen, mtrim, matt, oen, rtrim, ratt, drv, plfe, plfw,
		pre, proc, ptrim, lpf, hpf, comp, gain, in_sel, mic};
	scwl_host_model scwl_host_model_i (.o_sclk(sclk), .o_sdata(sdata), .o_cs_n(cs_n));
	scwl_top scwl_top_i (.I_CLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_SDATA(sdata),
		.I_CS_N(cs_n), .O_MIC_SEL(mic), .O_IN_SEL(in_sel), .O_IN_GAIN(gain), .O_COMP_EN(comp),
		.O_HPF_EN(hpf), .O_LPF_EN(lpf), .O_PRE_TRIM(ptrim), .O_PROC_SEL(proc),
		.O_PREEMPH_EN(pre), .O_PLF_WIDE(plfw), .O_PLF_EN(plfe), .O_DRV_SEL(drv),
		.O_REF_ATT(ratt), .O_REF_TRIM(rtrim), .O_OUT_EN(oen), .O_MAIN_ATT(matt),
		.O_MAIN_TRIM(mtrim), .O_RX_OUT_EN(rxen), .O_SQ_GAIN(sqg), .O_SQ_WIDE(sqw),
		.O_SQ_THR(thr), .O_SQ_SRC(src), .O_LOAD_PULSE(pulse), .O_LOADED(loaded));
	// -------------------------------------------
	// Clock, pulse count, watchdog
	// -------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (pulse === 1'b1) pulses++;
	// Eight frames take about 0.47 ms; about three times that before giving up
	initial begin
		#1500000;
		error_cnt++;
		test_done();
	end
	// -------------------------------------------
	// Shared tasks
	// -------------------------------------------
	task automatic check(input string what, input logic [46:0] exp, input logic [46:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Deselect, wait for the load pulse, then compare every field group
	task automatic finish(input scwl_word_t w);
		int n;
		int p;
		n = 0;
		p = pulses;
		scwl_host_model_i.latch_word();
		while (pulse !== 1'b1 && n < 10) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("load latency ok", 1, (n >= 3 && n <= 4));
		check("pre-process fields", w[13:0], act[13:0]);
		check("post-process fields", w[36:14], act[36:14]);
		check("squelch fields", w[46:37], act[46:37]);
		check("loaded flag", 1, loaded);
		@(posedge clk);
		#1;
		check("pulse width", 0, pulse);
		check("pulse count", p + 1, pulses);
	endtask
	task automatic load(input scwl_word_t w);
		scwl_host_model_i.shift_word(w);
		finish(w);
	endtask
	task automatic test_done();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// -------------------------------------------
	// Tests
	// -------------------------------------------
	initial begin
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		check("reset word", '0, act);
		check("reset loaded", 0, loaded);
		foreach (pats[i]) load(pats[i]);
		$display("test patterns done");
		// Staged word must not disturb the active one until deselect
		prev = act;
		pulses = pulses;
		scwl_host_model_i.shift_word(47'h1b3c_5d7e_9f01);
		check("active during shift", prev, act);
		check("no early pulse", 0, pulse);
		finish(47'h1b3c_5d7e_9f01);
		$display("test staging done");
		// Reset in mid-run clears the word; a later frame loads cleanly
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check("mid reset word", '0, act);
		check("mid reset loaded", 0, loaded);
		@(posedge clk);
		rst_n <= 1'b1;
		load(47'h2468_ace1_3579);
		$display("test second reset done");
		test_done();
	end
endmodule
